// ===== ext_bus_unit_pkg.sv
package ext_bus_unit_pkg;

    localparam int          NUM_CS                = 8;
    localparam int          NUM_CS_HIGH           = 4;
    localparam int          ADDR_W                = 24;
    localparam int          DATA_W                = 16;
    localparam logic [31:0] PREFETCH_ABORT_VECTOR = 32'h0000000c;
    localparam logic [31:0] DATA_ABORT_VECTOR     = 32'h00000010;
    localparam logic [23:0] ADDR_RESET            = 24'h000000;
    localparam logic [2:0]  FLOAT_RESET           = 3'h0;
    localparam logic [2:0]  FLOAT_STEP            = 3'h1;
    localparam logic [11:0] PAGE_MASK_ALL         = 12'hfff;

    typedef enum logic [4:0]
    {
        ST_IDLE   = 5'h01,
        ST_FLOAT  = 5'h02,
        ST_SETUP  = 5'h04,
        ST_STROBE = 5'h08,
        ST_HOLD   = 5'h10
    } bus_state_e;

    // One chip select: 1 MB base granularity, page = 1 MB << page_log2
    typedef struct packed
    {
        logic        enable;
        logic [11:0] base;
        logic [2:0]  page_log2;
        logic        bus16;
        logic        byte_select;
        logic [2:0]  float_wait_count;
    } chip_sel_config_s;

    typedef struct packed
    {
        logic byte0_write_strobe_n;
        logic byte1_write_strobe_n;
        logic read_strobe_low;
        logic write_enable_low;
        logic output_enable_low;
        logic upper_byte_sel_n;
        logic lower_byte_sel_n;
    } strobe_s;

    localparam strobe_s STROBE_IDLE = 7'h7f;

    typedef struct packed
    {
        bus_state_e  fsm;
        logic        busy;
        logic        ack;
        logic        abort_prefetch;
        logic        abort_data;
        logic [31:0] abort_vector;
        logic [23:0] cur_addr;
        logic [7:0]  cur_match;
        logic [2:0]  cur_cs;
        logic        cur_write;
        logic        cur_half;
        logic        cur_bus16;
        logic        cur_bsel;
        logic [2:0]  cur_float;
        logic        beat;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [2:0]  float_cnt;
        logic [2:0]  last_cs;
        logic [23:0] addr_pins;
        logic [3:0]  cs_low_n;
        strobe_s     strb;
        logic [15:0] data_out;
        logic        data_oe;
    } ebu_state_s;

endpackage

// ===== external_bus_interface.sv
`timescale 1ns/1ps
`default_nettype none

module external_bus_interface
    import ext_bus_unit_pkg::*;
(
    input  wire logic                     i_clk,
    input  wire logic                     i_reset_n,
    input  wire chip_sel_config_s [7:0]   i_chip_sel_config,
    input  wire logic [3:0]               i_high_cs_mode,
    input  wire logic                     i_req,
    input  wire logic [31:0]              i_req_addr,
    input  wire logic                     i_req_write,
    input  wire logic                     i_req_half,
    input  wire logic                     i_req_instr,
    input  wire logic                     i_req_internal,
    input  wire logic [15:0]              i_req_wdata,
    input  wire logic [15:0]              i_data_in,
    input  wire logic                     i_ext_wait_low,
    output var  logic                     o_busy,
    output var  logic                     o_ack,
    output var  logic [15:0]              o_rdata,
    output var  logic                     o_prefetch_abort,
    output var  logic                     o_data_abort,
    output var  logic [31:0]              o_abort_vector,
    output var  logic [23:0]              o_addr,
    output var  logic [3:0]               o_chip_sel_low_n,
    output var  logic [15:0]              o_data_out,
    output var  logic                     o_data_oe,
    output var  logic                     o_byte0_write_strobe_n,
    output var  logic                     o_byte1_write_strobe_n,
    output var  logic                     o_read_strobe_low,
    output var  logic                     o_write_enable_low,
    output var  logic                     o_output_enable_low,
    output var  logic                     o_upper_byte_sel_n,
    output var  logic                     o_lower_byte_sel_n
);

    logic [1:0]  rst_sync;
    logic        rst_n;
    ebu_state_s  st;
    ebu_state_s  next_st;
    logic [7:0]  hit;
    logic [2:0]  hit_cs;
    logic        wait_hold;
    logic        blocked;
    logic [1:0]  lanes;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Upper address bits are compared under the page mask only, so a small
    // device simply aliases through its whole page
    function automatic logic cs_hit(chip_sel_config_s c, logic [31:0] a);
        logic [11:0] mask;
        mask = PAGE_MASK_ALL << c.page_log2;
        return c.enable && ((a[31:20] & mask) == (c.base & mask));
    endfunction

    function automatic logic [2:0] lowest(logic [7:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int k = NUM_CS - 1; k >= 0; k--)
        begin
            if (m[k])
                idx = 3'(k);
        end
        return idx;
    endfunction

    // CS4 sits on A23 down to CS7 on A20
    function automatic logic [23:0] pin_addr(logic [23:0] a, logic [7:0] m,
                                             logic [3:0] mode);
        logic [23:0] p;
        p = a;
        for (int k = 0; k < NUM_CS_HIGH; k++)
        begin
            if (mode[k])
                p[23 - k] = m[4 + k];
        end
        return p;
    endfunction

    function automatic strobe_s strobe_for(logic wr, logic bsel, logic [1:0] ln);
        strobe_s s;
        s = STROBE_IDLE;
        if (bsel)
        begin
            s.write_enable_low  = !wr;
            s.output_enable_low = wr;
            s.upper_byte_sel_n  = !ln[1];
            s.lower_byte_sel_n  = !ln[0];
        end
        else
        begin
            s.read_strobe_low      = wr;
            s.byte0_write_strobe_n = !(wr && ln[0]);
            s.byte1_write_strobe_n = !(wr && ln[1]);
        end
        return s;
    endfunction

    generate
        for (genvar g = 0; g < NUM_CS; g++)
        begin : g_decode
            assign hit[g] = cs_hit(i_chip_sel_config[g], i_req_addr);
        end
    endgenerate

    assign hit_cs    = lowest(hit);
    assign wait_hold = !i_ext_wait_low &&
                       (st.fsm inside {ST_SETUP, ST_STROBE, ST_HOLD});
    assign blocked   = (st.float_cnt != FLOAT_RESET) &&
                       (i_req_write || (hit_cs != st.last_cs));

    always_comb
    begin
        next_st = st;
        lanes   = 2'h1;
        next_st.ack            = 1'b0;
        next_st.abort_prefetch = 1'b0;
        next_st.abort_data     = 1'b0;
        if (!wait_hold)
        begin
            if (st.float_cnt != FLOAT_RESET)
                next_st.float_cnt = st.float_cnt - FLOAT_STEP;
            case (st.fsm)
                ST_IDLE:
                begin
                    if (i_req && i_req_internal)
                    begin
                        next_st.ack = 1'b1;
                    end
                    else if (i_req && (hit == 8'h00))
                    begin
                        next_st.abort_prefetch = i_req_instr;
                        next_st.abort_data     = !i_req_instr;
                        next_st.abort_vector   = i_req_instr ? PREFETCH_ABORT_VECTOR
                                                             : DATA_ABORT_VECTOR;
                    end
                    else if (i_req)
                    begin
                        next_st.busy      = 1'b1;
                        next_st.cur_addr  = i_req_addr[23:0];
                        next_st.cur_match = hit;
                        next_st.cur_cs    = hit_cs;
                        next_st.cur_write = i_req_write;
                        next_st.cur_half  = i_req_half;
                        next_st.cur_bus16 = i_chip_sel_config[hit_cs].bus16;
                        next_st.cur_bsel  = i_chip_sel_config[hit_cs].byte_select;
                        next_st.cur_float = i_chip_sel_config[hit_cs].float_wait_count;
                        next_st.wdata     = i_req_wdata;
                        next_st.rdata     = 16'h0000;
                        next_st.beat      = 1'b0;
                        next_st.fsm       = blocked ? ST_FLOAT : ST_SETUP;
                    end
                end
                ST_FLOAT:
                begin
                    if (st.float_cnt == FLOAT_RESET)
                        next_st.fsm = ST_SETUP;
                end
                ST_SETUP:
                begin
                    next_st.fsm = ST_STROBE;
                end
                ST_STROBE:
                begin
                    next_st.fsm = ST_HOLD;
                    if (!st.cur_write)
                    begin
                        if (!st.cur_bus16)
                        begin
                            if (st.beat)
                                next_st.rdata[15:8] = i_data_in[7:0];
                            else
                                next_st.rdata[7:0] = i_data_in[7:0];
                        end
                        else if (st.cur_half)
                            next_st.rdata = i_data_in;
                        else
                            next_st.rdata = {8'h00, st.cur_addr[0] ? i_data_in[15:8]
                                                                   : i_data_in[7:0]};
                    end
                end
                ST_HOLD:
                begin
                    // Halfword on an 8-bit device takes two byte cycles
                    if (st.cur_half && !st.cur_bus16 && !st.beat)
                    begin
                        next_st.beat        = 1'b1;
                        next_st.cur_addr[0] = 1'b1;
                        next_st.fsm         = ST_SETUP;
                    end
                    else
                    begin
                        next_st.fsm  = ST_IDLE;
                        next_st.busy = 1'b0;
                        next_st.ack  = 1'b1;
                        if (!st.cur_write)
                        begin
                            next_st.float_cnt = st.cur_float;
                            next_st.last_cs   = st.cur_cs;
                        end
                    end
                end
                default:
                begin
                    next_st.fsm  = ST_IDLE;
                    next_st.busy = 1'b0;
                end
            endcase

            if (next_st.fsm == ST_SETUP && st.fsm != ST_SETUP)
            begin
                next_st.addr_pins = pin_addr(
                    {next_st.cur_addr[23:1], next_st.cur_addr[0] && !next_st.cur_bus16},
                    next_st.cur_match, i_high_cs_mode);
                next_st.cs_low_n  = ~next_st.cur_match[3:0];
                next_st.data_oe   = next_st.cur_write;
                if (!next_st.cur_bus16)
                    next_st.data_out = {8'h00, next_st.beat ? next_st.wdata[15:8]
                                                            : next_st.wdata[7:0]};
                else if (next_st.cur_half)
                    next_st.data_out = next_st.wdata;
                else
                    next_st.data_out = {next_st.wdata[7:0], next_st.wdata[7:0]};
            end
            if (next_st.fsm inside {ST_IDLE, ST_FLOAT})
            begin
                // Selects off, address pins follow cur_addr, so from its second cycle a float wait shows the next address
                next_st.addr_pins = pin_addr(st.cur_addr, 8'h00, i_high_cs_mode);
                next_st.cs_low_n  = 4'hf;
                next_st.data_oe   = 1'b0;
            end
            if (st.cur_bus16 && st.cur_half)
                lanes = 2'h3;
            else if (st.cur_bus16)
                lanes = st.cur_addr[0] ? 2'h2 : 2'h1;
            next_st.strb = (next_st.fsm == ST_STROBE)
                         ? strobe_for(st.cur_write, st.cur_bsel, lanes) : STROBE_IDLE;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st              <= '0;
            st.fsm          <= ST_IDLE;
            st.addr_pins    <= ADDR_RESET;
            st.cs_low_n     <= 4'hf;
            st.strb         <= STROBE_IDLE;
            st.float_cnt    <= FLOAT_RESET;
            st.abort_vector <= DATA_ABORT_VECTOR;
        end
        else
            st <= next_st;
    end

    assign o_busy                 = st.busy;
    assign o_ack                  = st.ack;
    assign o_rdata                = st.rdata;
    assign o_prefetch_abort       = st.abort_prefetch;
    assign o_data_abort           = st.abort_data;
    assign o_abort_vector         = st.abort_vector;
    assign o_addr                 = st.addr_pins;
    assign o_chip_sel_low_n       = st.cs_low_n;
    assign o_data_out             = st.data_out;
    assign o_data_oe              = st.data_oe;
    assign o_byte0_write_strobe_n = st.strb.byte0_write_strobe_n;
    assign o_byte1_write_strobe_n = st.strb.byte1_write_strobe_n;
    assign o_read_strobe_low      = st.strb.read_strobe_low;
    assign o_write_enable_low     = st.strb.write_enable_low;
    assign o_output_enable_low    = st.strb.output_enable_low;
    assign o_upper_byte_sel_n     = st.strb.upper_byte_sel_n;
    assign o_lower_byte_sel_n     = st.strb.lower_byte_sel_n;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    chk_overlap_all_sel: assert property (
        (st.fsm == ST_STROBE) |-> (o_chip_sel_low_n == ~st.cur_match[3:0]))
        else $error("chip selects do not follow all matches");
    chk_shared_addr_mode: assert property (
        (i_high_cs_mode == 4'h0 && st.fsm == ST_STROBE)
        |-> (o_addr[23:20] == st.cur_addr[23:20]))
        else $error("shared pins not acting as address");
    chk_a0_ignored: assert property (
        (st.fsm == ST_STROBE && st.cur_bus16) |-> (o_addr[0] == 1'b0))
        else $error("A0 driven on 16-bit device");
    chk_unmapped_abort: assert property (
        (st.fsm == ST_IDLE && i_req && !i_req_internal && hit == 8'h00)
        |=> ((o_prefetch_abort ^ o_data_abort) && !o_busy))
        else $error("unmapped access did not abort");
    chk_float_before_write: assert property (
        (st.fsm == ST_FLOAT) ##1 (st.fsm == ST_SETUP) |-> ($past(st.float_cnt) == 3'h0))
        else $error("external access before float waits ended");
    chk_internal_no_stall: assert property (
        (st.fsm == ST_IDLE && i_req && i_req_internal) |=> (o_ack && !o_busy))
        else $error("internal access stalled");
    chk_same_dev_read: assert property (
        (st.fsm == ST_IDLE && i_req && !i_req_internal && hit != 8'h00 &&
         !i_req_write && hit_cs == st.last_cs) |=> (st.fsm == ST_SETUP))
        else $error("float wait added for same device read");
    chk_wait_freeze: assert property (
        wait_hold |=> ($stable(o_addr) && $stable(st.fsm) && $stable(st.float_cnt)
                       && $stable(o_read_strobe_low) && $stable(o_output_enable_low)))
        else $error("state moved during external wait");
    chk_wait_resume: assert property (
        (st.fsm == ST_STROBE && i_ext_wait_low) |=> (st.fsm == ST_HOLD) ##1
        (st.fsm inside {ST_HOLD, ST_SETUP, ST_IDLE}))
        else $error("access did not resume after wait");
    chk_float_load: assert property (
        (st.fsm == ST_HOLD && i_ext_wait_low && !st.cur_write &&
         !(st.cur_half && !st.cur_bus16 && !st.beat)) |=> (st.float_cnt == $past(st.cur_float)))
        else $error("float countdown not loaded at read end");
    chk_bw_option: assert property (
        (st.fsm == ST_STROBE && !st.cur_bsel) |-> (o_write_enable_low && o_output_enable_low
         && o_upper_byte_sel_n && o_lower_byte_sel_n && (o_read_strobe_low == st.cur_write)))
        else $error("byte-select strobes active in byte-write option");
    chk_bs_option: assert property (
        (st.fsm == ST_STROBE && st.cur_bsel) |-> (o_byte0_write_strobe_n &&
         o_byte1_write_strobe_n && o_read_strobe_low && (o_write_enable_low == !st.cur_write)))
        else $error("byte-write strobes active in byte-select option");

    cov_float_wait: cover property ((st.fsm == ST_FLOAT) ##1 (st.fsm == ST_FLOAT));
    cov_ext_wait: cover property (wait_hold && st.fsm == ST_STROBE);
    cov_two_beat: cover property (st.fsm == ST_HOLD && st.beat);
    cov_overlap: cover property (st.fsm == ST_STROBE && st.cur_match[1:0] == 2'h3);

endmodule

`default_nettype wire

// ===== ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module ext_mem_model
(
    input  wire logic [0:0]  i_clk,
    input  wire logic [23:0] i_addr,
    input  wire logic [15:0] i_data_out,
    input  wire logic        i_data_oe,
    input  wire logic [1:0]  i_rd_n,
    input  wire logic [2:0]  i_wr_n,
    input  wire logic [2:0]  i_hold,
    output var  logic [15:0] o_data_in,
    output var  logic        o_wait_low,
    output var  logic [15:0] o_wdata
);
    logic [2:0]  held = 3'h0;
    logic [15:0] last = 16'h0000;
    wire  logic  reading = !(&i_rd_n);
    wire  logic  active = reading || !(&i_wr_n);

    // Only A7..A0 decode, so the image repeats over the page; released bus shows no stale value
    assign o_data_in = reading ? {~i_addr[7:0], i_addr[7:0] + 8'h3c} : ~last;
    // Combinational so the stall lands on the first strobe edge
    assign o_wait_low = !(active && held < i_hold);

    always @(posedge i_clk)
    begin
        held <= !active ? 3'h0 : (o_wait_low ? held : held + 3'h1);
        if (reading)
            last <= o_data_in;
        if (i_data_oe && !(&i_wr_n))
            o_wdata <= i_data_out;
    end
endmodule

`default_nettype wire

// ===== external_bus_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none

module external_bus_interface_bench
    import ext_bus_unit_pkg::*;
();
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   req = 1'b0;
    logic                   wr = 1'b0;
    logic                   half = 1'b0;
    logic                   instr = 1'b0;
    logic                   intl = 1'b0;
    logic [31:0]            a = 32'h0;
    logic [15:0]            wd = 16'h0;
    logic [2:0]             hold = 3'h0;
    logic [3:0]             cs_mode = 4'h1;
    chip_sel_config_s [7:0] cfg;
    logic [15:0]            din, rdata, dout, mdata;
    logic [31:0]            vec;
    logic [23:0]            addr;
    logic [3:0]             csl_n;
    logic                   wait_low, busy, ack, pab, dab, oe;
    logic                   b0_n, b1_n, rd_n, we_n, oe_n, ub_n, lb_n;
    logic [9:0]             seen;
    int                     bad_count = 0;
    int                     num_checks = 0;
    int                     lat;
    int                     busy_cnt;

    always #5 clk = ~clk;

    external_bus_interface i_dut
    (
        .i_clk(clk), .i_reset_n(rst_n), .i_chip_sel_config(cfg), .i_high_cs_mode(cs_mode),
        .i_req(req), .i_req_addr(a), .i_req_write(wr), .i_req_half(half),
        .i_req_instr(instr), .i_req_internal(intl), .i_req_wdata(wd), .i_data_in(din),
        .i_ext_wait_low(wait_low), .o_busy(busy), .o_ack(ack), .o_rdata(rdata),
        .o_prefetch_abort(pab), .o_data_abort(dab), .o_abort_vector(vec), .o_addr(addr),
        .o_chip_sel_low_n(csl_n), .o_data_out(dout), .o_data_oe(oe),
        .o_byte0_write_strobe_n(b0_n), .o_byte1_write_strobe_n(b1_n),
        .o_read_strobe_low(rd_n), .o_write_enable_low(we_n), .o_output_enable_low(oe_n),
        .o_upper_byte_sel_n(ub_n), .o_lower_byte_sel_n(lb_n)
    );

    ext_mem_model i_mem
    (
        .i_clk(clk), .i_addr(addr), .i_data_out(dout), .i_data_oe(oe),
        .i_rd_n({rd_n, oe_n}), .i_wr_n({b0_n, b1_n, we_n}), .i_hold(hold),
        .o_data_in(din), .o_wait_low(wait_low), .o_wdata(mdata)
    );

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One access; lat counts edges from the taking edge to the answer
    task automatic issue(input logic [31:0] ad, input logic w, h, ins, inl,
                         input logic [15:0] d);
        @(negedge clk);
        a = ad;
        wr = w;
        half = h;
        instr = ins;
        intl = inl;
        wd = d;
        req = 1'b1;
        lat = 0;
        busy_cnt = 0;
        seen = 10'h0;
        do
        begin
            @(negedge clk);
            req = 1'b0;
            lat++;
            busy_cnt += busy;
            seen |= {~csl_n[1:0], addr[23], ~rd_n, ~oe_n, ~we_n, ~b0_n, ~b1_n, ~ub_n, ~lb_n};
        end while (!(ack === 1'b1 || pab === 1'b1 || dab === 1'b1) && lat < 40);
        if (lat >= 40)
        begin
            bad_count++;
            conclude();
        end
    endtask

    task automatic t_reset();
        check(addr, 32'h0);
        check(csl_n, 32'hf);
        check({b0_n, b1_n, rd_n, we_n, oe_n, ub_n, lb_n, busy}, 32'hfe);
    endtask

    task automatic t_overlap_read();
        issue(32'h01000010, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
        check(lat, 4);
        check(rdata, 32'hef4c);
        // Both selects low, byte-write strobes taken from the lower one
        check(seen, 32'h340);
        issue(32'h010f0010, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
        check(lat, 4);
        check(rdata, 32'hef4c);
    endtask

    task automatic t_float_write();
        issue(32'h01000020, 1'b1, 1'b1, 1'b0, 1'b0, 16'hbeef);
        check(lat, 10);
        check(mdata, 32'hbeef);
        check(seen, 32'h30c);
    endtask

    task automatic t_float_internal();
        issue(32'h01000030, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
        issue(32'h00000100, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0);
        check(lat, 1);
        // Internal access leaves the last external read data standing
        check(rdata, 32'hcf6c);
        check(busy_cnt, 0);
        issue(32'h00000104, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0);
        check(lat, 1);
        // Countdown ran on during the internal accesses
        issue(32'h02000004, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0);
        check(lat, 6);
        check(rdata[7:0], 32'h40);
    endtask

    task automatic t_narrow_half();
        issue(32'h02000006, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
        check(lat, 7);
        check(rdata, 32'h4342);
    endtask

    task automatic t_byte_select();
        issue(32'h03000001, 1'b1, 1'b0, 1'b0, 1'b0, 16'h005a);
        check(lat, 4);
        check(mdata[15:8], 32'h5a);
        check(seen, 32'h092);
    endtask

    task automatic t_ext_wait();
        hold = 3'h3;
        issue(32'h03000008, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
        hold = 3'h0;
        check(lat, 7);
        check(rdata, 32'hf744);
        check(seen, 32'h0a3);
    endtask

    task automatic t_abort();
        issue(32'h05000000, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0);
        check({lat[3:0], pab, dab}, 32'h6);
        @(negedge clk);
        check(vec, 32'h0000000c);
        issue(32'h05000004, 1'b1, 1'b1, 1'b0, 1'b0, 16'h1);
        check({lat[3:0], pab, dab}, 32'h5);
        @(negedge clk);
        check(vec, 32'h00000010);
    endtask

    task automatic t_addr_mode();
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        t_reset();
        rst_n = 1'b1;
        cs_mode = 4'h0;
        repeat (3) @(posedge clk);
        issue(32'h03800008, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
        check(lat, 4);
        check(busy_cnt, 3);
        check(rdata, 32'hf744);
        // Shared pin carries A23 while in address use
        check(seen, 32'h0a3);
        cs_mode = 4'h1;
        issue(32'h03800008, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
        check(seen, 32'h023);
    endtask

    initial
    begin
        cfg = '0;
        cfg[0] = {1'b1, 12'h010, 3'h0, 1'b1, 1'b0, 3'h7};
        cfg[1] = {1'b1, 12'h010, 3'h0, 1'b1, 1'b1, 3'h0};
        cfg[2] = {1'b1, 12'h020, 3'h0, 1'b0, 1'b1, 3'h0};
        cfg[4] = {1'b1, 12'h030, 3'h0, 1'b1, 1'b1, 3'h0};
        cfg[5] = {1'b1, 12'h038, 3'h0, 1'b1, 1'b1, 3'h0};
        repeat (10) @(negedge clk);
        t_reset();
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        t_overlap_read();
        t_float_write();
        t_float_internal();
        t_narrow_half();
        t_byte_select();
        t_ext_wait();
        t_abort();
        t_addr_mode();
        conclude();
    end
endmodule

`default_nettype wire
